/* design/fctc_config_regs.sv */
/*
 * fctc_config_regs: flash current select and flash timeout/limit
 * registers, their decode into currents and limits, and the timeout timer.
 * assumes: the serial front end presents one byte access at a time on
 * reg_addr/reg_wdata with one-cycle reg_wr or reg_rd strobes, synchronous
 * to ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module fctc_config_regs
    import fctc_pkg::*;
#(
    parameter int CYCLES_PER_MS = FCTC_CYCLES_PER_MS
)
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire logic flash_start,
    input wire logic flash_stop,
    output logic [3:0] led1_flash_code,
    output logic [3:0] led2_flash_code,
    output logic [19:0] led1_current_ua,
    output logic [19:0] led2_current_ua,
    output logic [4:0] timeout_sel,
    output logic [1:0] limit_sel,
    output logic [11:0] limit_ma,
    output logic flash_active,
    output logic flash_timeout
);

    logic [7:0] cur_sel_ff;
    logic [6:0] tmo_lim_ff;
    logic [7:0] rdata_ff;
    logic [11:0] limit_ma_ff;
    logic [19:0] current_ff [FCTC_NUM_LED];
    logic [3:0] led_code [FCTC_NUM_LED];
    logic hit_cur;
    logic hit_tmo;
    logic [11:0] nxt_limit_ma;
    logic cur_written_ff;
    logic tmo_written_ff;

    // address decode
    assign hit_cur = (reg_addr == FCTC_ADDR_CURRENT);
    assign hit_tmo = (reg_addr == FCTC_ADDR_TIMEOUT);
    assign reg_hit = hit_cur || hit_tmo;

    // field extraction
    assign led1_flash_code = cur_sel_ff[FCTC_LED1_LSB +: FCTC_CODE_W];
    assign led2_flash_code = cur_sel_ff[FCTC_LED2_LSB +: FCTC_CODE_W];
    assign timeout_sel = tmo_lim_ff[FCTC_TMO_LSB +: FCTC_TMO_W];
    assign limit_sel = tmo_lim_ff[FCTC_LIM_LSB +: FCTC_LIM_W];
    assign led_code[0] = led1_flash_code;
    assign led_code[1] = led2_flash_code;
    assign led1_current_ua = current_ff[0];
    assign led2_current_ua = current_ff[1];
    assign limit_ma = limit_ma_ff;
    assign reg_rdata = rdata_ff;

    // current select register; writes to other addresses leave it alone
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            cur_sel_ff <= FCTC_RST_CURRENT;
        else if (reg_wr && hit_cur)
            cur_sel_ff <= reg_wdata;
    end

    // timeout/limit register; bit 7 is not stored since it does nothing
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            tmo_lim_ff <= FCTC_RST_TIMEOUT[FCTC_STORED_W-1:0];
        else if (reg_wr && hit_tmo)
            tmo_lim_ff <= reg_wdata[FCTC_STORED_W-1:0];
    end

    // read data registered; unmapped addresses and bit 7 of the timeout register read zero
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_ff <= 8'h00;
        else if (reg_rd)
        begin
            if (hit_cur)
                rdata_ff <= cur_sel_ff;
            else if (hit_tmo)
                rdata_ff <= {1'b0, tmo_lim_ff};
            else
                rdata_ff <= 8'h00;
        end
    end

    // per-channel current decode, one cycle behind the code
    genvar ch;
    generate
        for (ch = 0; ch < FCTC_NUM_LED; ch++)
        begin : g_led
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                    current_ff[ch] <= 20'h00000;
                else
                    current_ff[ch] <= 20'((20'(led_code[ch]) + 20'h00001)
                                          * FCTC_CUR_STEP_UA);
            end
        end
    endgenerate

    // limit decode lookup
    always_comb
    begin
        unique case (limit_sel)
            2'h0: nxt_limit_ma = FCTC_LIM0_MA;
            2'h1: nxt_limit_ma = FCTC_LIM1_MA;
            2'h2: nxt_limit_ma = FCTC_LIM2_MA;
            2'h3: nxt_limit_ma = FCTC_LIM3_MA;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            limit_ma_ff <= 12'h000;
        else
            limit_ma_ff <= nxt_limit_ma;
    end

    // timeout timer consumes the live timeout code
    fctc_flash_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timer (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .flash_start(flash_start),
        .flash_stop(flash_stop),
        .timeout_code(timeout_sel),
        .flash_active(flash_active),
        .flash_timeout(flash_timeout)
    );

    // helpers for checks: has each register been written since reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cur_written_ff <= 1'b0;
            tmo_written_ff <= 1'b0;
        end
        else
        begin
            if (reg_wr && hit_cur)
                cur_written_ff <= 1'b1;
            if (reg_wr && hit_tmo)
                tmo_written_ff <= 1'b1;
        end
    end

    sequence s_wr_cur;
        reg_wr && hit_cur;
    endsequence

    sequence s_rd_cur_quiet;
        reg_rd && hit_cur && !reg_wr;
    endsequence

    chk_led_fields: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        s_wr_cur |=> led1_flash_code == $past(reg_wdata[3:0])
                     && led2_flash_code == $past(reg_wdata[7:4]))
        else $error("led flash codes not taken from write");

    chk_cur_readback: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        s_wr_cur ##1 s_rd_cur_quiet |=> reg_rdata == $past(reg_wdata, 2))
        else $error("current select read back wrong");

    chk_cur_hold: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !(reg_wr && hit_cur) |=> $stable(cur_sel_ff))
        else $error("current select changed without write");

    chk_cur_reset: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !cur_written_ff |-> led1_flash_code == 4'hd
                            && led2_flash_code == 4'hd)
        else $error("current codes not at reset value");

    chk_cur_decode: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        s_wr_cur ##1 !(reg_wr && hit_cur) |=>
            led2_current_ua == 20'(($past(reg_wdata[7:4], 2) + 20'h1)
                                   * 20'h0dbba))
        else $error("led2 current decode wrong");

    chk_tmo_fields: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        reg_wr && hit_tmo |=> timeout_sel == $past(reg_wdata[4:0])
                              && limit_sel == $past(reg_wdata[6:5]))
        else $error("timeout or limit field not taken from write");

    chk_bit7_zero: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        reg_rd && hit_tmo |=> reg_rdata[7] == 1'b0)
        else $error("unused bit 7 read as one");

    chk_limit_reset: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !tmo_written_ff |-> limit_sel == 2'h3 && timeout_sel == 5'h0f)
        else $error("limit or timeout not at reset value");

    chk_limit_decode: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        ##1 $past(limit_sel) == 2'h2 |-> limit_ma == 12'ha8c)
        else $error("limit decode for 2.7 A wrong");

endmodule : fctc_config_regs
`default_nettype wire

/* design/fctc_pkg.sv */
/*
 * fctc_pkg: shared constants and types of the flash current and timeout
 * configuration bank: register addresses, field positions, reset values,
 * decode steps and timing counts.
 * assumes: a 10 MHz ref_clk; registers are reached by the serial control
 * front end through an internal byte address.
 */
package fctc_pkg;

    // internal register addresses
    localparam logic [7:0] FCTC_ADDR_CURRENT = 8'hb0;
    localparam logic [7:0] FCTC_ADDR_TIMEOUT = 8'hc0;

    // reset values
    localparam logic [7:0] FCTC_RST_CURRENT = 8'hdd;
    localparam logic [7:0] FCTC_RST_TIMEOUT = 8'h6f;

    // field layout of the current select register
    localparam int FCTC_CODE_W = 4;
    localparam int FCTC_LED1_LSB = 0;
    localparam int FCTC_LED2_LSB = 4;
    localparam int FCTC_NUM_LED = 2;

    // field layout of the timeout and limit register
    localparam int FCTC_TMO_W = 5;
    localparam int FCTC_TMO_LSB = 0;
    localparam int FCTC_LIM_W = 2;
    localparam int FCTC_LIM_LSB = 5;
    localparam int FCTC_STORED_W = 7;

    // decode steps
    localparam int FCTC_CUR_W = 20;
    localparam logic [19:0] FCTC_CUR_STEP_UA = 20'h0dbba;
    localparam logic [11:0] FCTC_LIM0_MA = 12'h578;
    localparam logic [11:0] FCTC_LIM1_MA = 12'h834;
    localparam logic [11:0] FCTC_LIM2_MA = 12'ha8c;
    localparam logic [11:0] FCTC_LIM3_MA = 12'hc80;

    // timing
    localparam logic [10:0] FCTC_TMO_STEP_MS = 11'h020;
    localparam int FCTC_CLK_HZ = 10_000_000;
    localparam int FCTC_MS_PER_S = 1000;
    localparam int FCTC_CYCLES_PER_MS = FCTC_CLK_HZ / FCTC_MS_PER_S;

    typedef enum logic {FCTC_TMR_IDLE, FCTC_TMR_RUN} fctc_tmr_state_t;

endpackage : fctc_pkg

/* design/fctc_flash_timer.sv */
/*
 * fctc_flash_timer: flash timeout timer, (code+1) x 32 ms per flash.
 * assumes: start and stop are one-cycle pulses from the flash sequencer,
 * synchronous to ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module fctc_flash_timer
    import fctc_pkg::*;
#(
    parameter int CYCLES_PER_MS = FCTC_CYCLES_PER_MS
)
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic flash_start,
    input wire logic flash_stop,
    input wire logic [4:0] timeout_code,
    output logic flash_active,
    output logic flash_timeout
);

    fctc_tmr_state_t state_ff;
    logic [23:0] div_ff;
    logic [10:0] ms_ff;
    logic [10:0] span_ff;
    logic timeout_ff;
    logic ms_tick;
    logic last_ms;
    logic [31:0] elapsed_ff;

    // one-cycle enable each millisecond while running
    assign ms_tick = (div_ff == 24'(CYCLES_PER_MS - 1));
    assign last_ms = ms_tick && (ms_ff == 11'(span_ff - 11'h001));
    assign flash_active = (state_ff == FCTC_TMR_RUN);
    assign flash_timeout = timeout_ff;

    // run state; stop beats start, timeout fires on the last ms tick
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= FCTC_TMR_IDLE;
            timeout_ff <= 1'b0;
        end
        else
        begin
            timeout_ff <= 1'b0;
            unique case (state_ff)
                FCTC_TMR_IDLE:
                begin
                    if (flash_start && !flash_stop)
                        state_ff <= FCTC_TMR_RUN;
                end
                FCTC_TMR_RUN:
                begin
                    if (flash_stop)
                        state_ff <= FCTC_TMR_IDLE;
                    else if (flash_start)
                        state_ff <= FCTC_TMR_RUN; // retrigger restarts
                    else if (last_ms)
                    begin
                        state_ff <= FCTC_TMR_IDLE;
                        timeout_ff <= 1'b1;
                    end
                end
            endcase
        end
    end

    // span latched at start so a rewrite mid-flash cannot cut it short
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            span_ff <= FCTC_TMO_STEP_MS;
        else if (flash_start)
            span_ff <= 11'((11'(timeout_code) + 11'h001)
                           * FCTC_TMO_STEP_MS);
    end

    // millisecond divider and ms counter
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_ff <= 24'h000000;
            ms_ff <= 11'h000;
        end
        else if (flash_start)
        begin
            div_ff <= 24'h000000;
            ms_ff <= 11'h000;
        end
        else if (flash_active)
        begin
            if (ms_tick)
            begin
                div_ff <= 24'h000000;
                ms_ff <= 11'(ms_ff + 11'h001);
            end
            else
                div_ff <= 24'(div_ff + 24'h000001);
        end
    end

    // helper for checks: cycles spent running since the last start
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            elapsed_ff <= 32'h00000000;
        else if (flash_start)
            elapsed_ff <= 32'h00000000;
        else if (flash_active)
            elapsed_ff <= 32'(elapsed_ff + 32'h00000001);
    end

    chk_timeout_length: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flash_timeout |->
            elapsed_ff == 32'(32'(span_ff) * 32'(CYCLES_PER_MS)))
        else $error("flash timeout length wrong");

    chk_start_runs: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flash_start && !flash_stop |=> flash_active && !flash_timeout)
        else $error("timer did not start");

    chk_stop_idles: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flash_stop |=> !flash_active && !flash_timeout)
        else $error("timer did not stop");

endmodule : fctc_flash_timer
`default_nettype wire

/* bench/test_fctc_config_regs.sv */
/*
 * test_flash_current_timeout_config: self-checking bench for the flash
 * current select and timeout/limit registers and the timeout timer.
 * assumes: fctc_pkg compiled first; the timer is shortened with
 * CYCLES_PER_MS = 2 so that a 1024 ms flash stays a short run.
 */
`timescale 1ns/10ps
`default_nettype none
module test_flash_current_timeout_config
    import fctc_pkg::*;
;
    localparam int CPM = 2;
    localparam int MAX_CYC = 20000;
    typedef struct {logic [7:0] addr; logic [7:0] wd;
                    logic [7:0] rd;} fctc_row_t;
    logic ref_clk, arst_n, reg_wr, reg_rd, flash_start, flash_stop;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, sh_cur, sh_tmo;
    logic reg_hit, flash_active, flash_timeout;
    logic [3:0] led1_flash_code, led2_flash_code;
    logic [19:0] led1_current_ua, led2_current_ua;
    logic [4:0] timeout_sel;
    logic [1:0] limit_sel;
    logic [11:0] limit_ma;
    logic [11:0] lim_tab [4];
    fctc_row_t rows[$];
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int n;

    fctc_config_regs #(.CYCLES_PER_MS(CPM)) i_fctc_config_regs (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .flash_start(flash_start), .flash_stop(flash_stop),
        .led1_flash_code(led1_flash_code), .led2_flash_code(led2_flash_code),
        .led1_current_ua(led1_current_ua), .led2_current_ua(led2_current_ua),
        .timeout_sel(timeout_sel), .limit_sel(limit_sel),
        .limit_ma(limit_ma), .flash_active(flash_active),
        .flash_timeout(flash_timeout));

    // free-running 10 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // hang guard: a stuck run counts as a mismatch
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == MAX_CYC)
        begin
            errors++;
            $display("mismatch at %0t: cycle limit reached", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, what,
                     got, exp);
        end
    endtask : chk

    // inputs always move 1 ns after the edge, never on it
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        // reg_hit is combinational: look at it once the address has settled
        chk(reg_hit, a == FCTC_ADDR_CURRENT || a == FCTC_ADDR_TIMEOUT, "hit");
        reg_rd = 1'b0;
        chk(reg_rdata, exp, "rdata");
    endtask : rd

    // expected outputs worked out from the shadow copies
    task automatic fields();
        chk(led1_flash_code, sh_cur[3:0], "led1 code");
        chk(led2_flash_code, sh_cur[7:4], "led2 code");
        chk(led1_current_ua,
            (32'(sh_cur[3:0]) + 1) * FCTC_CUR_STEP_UA, "i1");
        chk(led2_current_ua,
            (32'(sh_cur[7:4]) + 1) * FCTC_CUR_STEP_UA, "i2");
        chk(timeout_sel, sh_tmo[4:0], "tmo sel");
        chk(limit_sel, sh_tmo[6:5], "lim sel");
        chk(limit_ma, lim_tab[sh_tmo[6:5]], "lim ma");
    endtask : fields

    task automatic do_reset();
        arst_n = 1'b0;
        tick(20);
        arst_n = 1'b1;
        sh_cur = {4'hd, 4'hd};
        sh_tmo = {1'h0, 2'h3, 5'h0f};
        tick(2);
        fields();
        rd(FCTC_ADDR_CURRENT, 8'hdd);
        rd(FCTC_ADDR_TIMEOUT, 8'h6f);
    endtask : do_reset

    initial
    begin
        {reg_wr, reg_rd, flash_start, flash_stop} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        lim_tab = '{FCTC_LIM0_MA, FCTC_LIM1_MA, FCTC_LIM2_MA, FCTC_LIM3_MA};
        // every current code on both channels, every timeout and limit code
        for (int i = 0; i < 16; i++)
            rows.push_back('{FCTC_ADDR_CURRENT, {4'(i), 4'(15 - i)},
                             {4'(i), 4'(15 - i)}});
        rows.push_back('{8'hb1, 8'hff, 8'h00});
        for (int i = 0; i < 32; i++)
            rows.push_back('{FCTC_ADDR_TIMEOUT, {1'(i), 2'(i), 5'(i)},
                             {1'h0, 2'(i), 5'(i)}});
        rows.push_back('{8'ha0, 8'hff, 8'h00});
        do_reset();
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wd);
            if (rows[i].addr == FCTC_ADDR_CURRENT)
                sh_cur = rows[i].wd;
            if (rows[i].addr == FCTC_ADDR_TIMEOUT)
                sh_tmo = rows[i].wd & 8'h7f;
            tick(2);
            fields();
            rd(rows[i].addr, rows[i].rd);
        end
        // a read straight after a write must see the new byte
        wr(FCTC_ADDR_CURRENT, 8'h5a);
        rd(FCTC_ADDR_CURRENT, 8'h5a);
        // shortest and longest timeout
        foreach (lim_tab[j])
        begin
            if (j == 1 || j == 2)
                continue;
            wr(FCTC_ADDR_TIMEOUT, {3'h0, 5'(j == 0 ? 0 : 31)});
            flash_start = 1'b1;
            tick(1);
            flash_start = 1'b0;
            n = 1;
            while (flash_timeout !== 1'b1 && n < 3000)
            begin
                tick(1);
                n++;
            end
            chk(n,
                (j == 0 ? 1 : 32) * 32'(FCTC_TMO_STEP_MS) * CPM + 1, "tmo");
            chk(flash_active, 1'b0, "active end");
        end
        // abort in mid-flash: no timeout may follow
        flash_start = 1'b1;
        tick(1);
        flash_start = 1'b0;
        tick(5);
        chk(flash_active, 1'b1, "active run");
        flash_stop = 1'b1;
        tick(1);
        flash_stop = 1'b0;
        chk(flash_active, 1'b0, "active stop");
        for (int k = 0; k < 2100; k++)
        begin
            if (flash_timeout !== 1'b0)
                chk(flash_timeout, 1'b0, "late timeout");
            tick(1);
        end
        // reset after a timeout register write must bring back the defaults
        wr(FCTC_ADDR_TIMEOUT, 8'h81);
        do_reset();
        final_report();
    end

endmodule : test_flash_current_timeout_config
`default_nettype wire
